/* File: rtl/dbg_acq_pkg.sv */
// constants and types for debug port acquisition and lockout
// Summary of operation
// - debug link enabled on one pin pair only
// - acquire pattern inside 8 us window enables pair
// - latch config selects link on scan pair directly
// - link reacquirable every reset, may re-enable scan
// - clock from host, data pin driven in turns
// - scan port enables link; link can be disabled
// - fixed 32-bit key arms permanent port lockout
// - latch votes 1 when 28 of 32 match
// - vote 1 blocks debug, test and latch changes
// - latch output sampled only at reset
// - lock needs load, commit, then reset
// - key write accepted only without flash protection
// - access stays until next reset after key write
// - latch contents readable over debug link
// - protection cleared only by full device erase
// - block operations only where block security allows
// - link with either trace, scan with parallel only
// - single pin trace excludes full scan debug
// - parallel trace port uses five pins
package dbg_acq_pkg;
    localparam int CLK_MHZ = 250;
    localparam int KEY_WINDOW_NS = 8000;
    localparam int KEY_WINDOW_CYC = KEY_WINDOW_NS * CLK_MHZ / 1000;
    localparam int LOCK_BITS = 32;
    localparam int LOCK_VOTE_MIN = 28;
    // arbitrary key value
    localparam logic [31:0] LOCK_KEY = 32'hA5C3_96E1;
    localparam int ACQ_LEN = 16;
    localparam logic [15:0] ACQ_PATTERN = 16'hC5A3;
    localparam int TRACE_PINS = 5;
    localparam logic [1:0] CFG_JTAG = 2'h0;
    localparam logic [1:0] CFG_SWD = 2'h1;
    localparam logic [1:0] CFG_NONE = 2'h2;
    localparam logic [1:0] TRACE_OFF = 2'h0;
    localparam logic [1:0] TRACE_SINGLE = 2'h1;
    localparam logic [1:0] TRACE_PARALLEL = 2'h2;
    localparam logic [1:0] OP_ERASE_ALL = 2'h0;
    localparam logic [1:0] OP_ERASE_BLK = 2'h1;
    localparam logic [1:0] OP_PROGRAM = 2'h2;
    localparam logic [1:0] OP_VERIFY = 2'h3;
    typedef enum logic [1:0] {PAIR_NONE, PAIR_BS, PAIR_USB} swd_pair_t;
endpackage

/* File: rtl/acquire_detector.sv */
// acquire pattern detector for one pin pair
`timescale 1ns/1ps
`default_nettype none
module acquire_detector #(
    parameter int LEN = dbg_acq_pkg::ACQ_LEN,
    parameter logic [LEN-1:0] PATTERN = dbg_acq_pkg::ACQ_PATTERN
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic link_clk_i,
    input wire logic link_dio_i,
    input wire logic enable_i,
    output logic match_o
);
    logic clk_s1, clk_s2, clk_s3, dio_s1, dio_s2;
    logic [LEN-1:0] shift, next_shift;
    logic next_match, rise;

    assign rise = clk_s2 && !clk_s3;

    always_comb begin
        next_shift = shift;
        next_match = 1'b0;
        if (rise) begin
            next_shift = {shift[LEN-2:0], dio_s2};
            // pattern seen on a link clock rising edge
            next_match = enable_i && ({shift[LEN-2:0], dio_s2} == PATTERN);
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            clk_s1 <= 1'b0;
            clk_s2 <= 1'b0;
            clk_s3 <= 1'b0;
            dio_s1 <= 1'b0;
            dio_s2 <= 1'b0;
            shift <= '0;
            match_o <= 1'b0;
        end else begin
            clk_s1 <= link_clk_i;
            clk_s2 <= clk_s1;
            clk_s3 <= clk_s2;
            dio_s1 <= link_dio_i;
            dio_s2 <= dio_s1;
            shift <= next_shift;
            match_o <= next_match;
        end
    end

    property p_match_on_edge;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        match_o |-> $past(rise) && $past(enable_i);
    endproperty
    a_match_on_edge: assert property (p_match_on_edge)
        else $error("match without link clock edge");
endmodule
`default_nettype wire

/* File: rtl/debug_port_acquire_and_lock.sv */
// debug port acquisition, trace selection, flash gating and lockout
`timescale 1ns/1ps
`default_nettype none
module debug_port_acquire_and_lock #(
    parameter int KEY_WIN_CYC = dbg_acq_pkg::KEY_WINDOW_CYC,
    parameter logic [31:0] LOCK_KEY = dbg_acq_pkg::LOCK_KEY
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic bs_clk_i,
    input wire logic bs_dio_i,
    output logic bs_dio_o,
    output logic bs_dio_oe_o,
    input wire logic usb_clk_i,
    input wire logic usb_dio_i,
    output logic usb_dio_o,
    output logic usb_dio_oe_o,
    input wire logic [1:0] cfg_dbg_sel_i,
    input wire logic swd_tx_turn_i,
    input wire logic swd_tx_bit_i,
    input wire logic swd_disable_i,
    input wire logic jtag_swd_enable_i,
    input wire logic swd_jtag_enable_i,
    input wire logic [1:0] trace_mode_i,
    input wire logic swo_bit_i,
    input wire logic [4:0] trace_word_i,
    input wire logic [31:0] lock_key_i,
    input wire logic lock_key_wr_i,
    input wire logic lock_commit_i,
    input wire logic nv_restore_i,
    input wire logic [31:0] nv_image_i,
    input wire logic [1:0] flash_prot_level_i,
    input wire logic flash_req_i,
    input wire logic [1:0] flash_op_i,
    input wire logic [2:0] blk_sec_allow_i,
    output logic swd_bs_en_o,
    output logic swd_usb_en_o,
    output logic jtag_en_o,
    output logic bs_pins_gpio_o,
    output logic usb_pins_gpio_o,
    output logic swo_en_o,
    output logic swo_o,
    output logic par_trace_en_o,
    output logic [4:0] par_trace_o,
    output logic lock_active_o,
    output logic lock_vote_o,
    output logic lock_wr_refused_o,
    output logic [31:0] lock_readback_o,
    output logic flash_grant_o,
    output logic flash_deny_o,
    output logic flash_prot_clear_o
);
    localparam int CW = $clog2(KEY_WIN_CYC + 1);
    localparam logic [CW-1:0] WIN_END = CW'(KEY_WIN_CYC);

    dbg_acq_pkg::swd_pair_t swd_pair, next_swd_pair;
    logic [CW-1:0] win_cnt, next_win_cnt;
    logic init_done, lock_active, jtag_en;
    logic next_lock_active, next_jtag_en;
    logic [31:0] vol_key, next_vol_key, nv_cells, next_nv_cells;
    logic win_open, vote_now, refuse_wr, access, op_allowed;
    logic bs_match, usb_match, det_en;
    logic next_refused, next_grant, next_deny, next_clear;
    logic next_swo_en, next_par_en;
    logic [31:0] next_readback;
    function automatic logic vote(input logic [31:0] cells);
        int n;
        n = 0;
        for (int i = 0; i < dbg_acq_pkg::LOCK_BITS; i++) begin
            n = n + ((cells[i] == LOCK_KEY[i]) ? 1 : 0);
        end
        return n >= dbg_acq_pkg::LOCK_VOTE_MIN;
    endfunction
    // window timed from reset release
    assign win_open = init_done && (win_cnt < WIN_END);
    assign vote_now = vote(nv_cells);
    // latch frozen by vote, key only without protection
    assign refuse_wr = vote_now || (flash_prot_level_i != 2'h0);
    assign access = !lock_active &&
        (jtag_en || swd_pair != dbg_acq_pkg::PAIR_NONE);
    // patterns ignored under lockout or once a pair is held
    assign det_en = win_open && !lock_active &&
        swd_pair == dbg_acq_pkg::PAIR_NONE;
    assign op_allowed = (flash_op_i == dbg_acq_pkg::OP_ERASE_ALL) ||
        blk_sec_allow_i[flash_op_i - 2'h1];
    acquire_detector #(
        .LEN(dbg_acq_pkg::ACQ_LEN),
        .PATTERN(dbg_acq_pkg::ACQ_PATTERN)
    ) u_bs_det (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .link_clk_i(bs_clk_i),
        .link_dio_i(bs_dio_i),
        .enable_i(det_en),
        .match_o(bs_match)
    );

    acquire_detector #(
        .LEN(dbg_acq_pkg::ACQ_LEN),
        .PATTERN(dbg_acq_pkg::ACQ_PATTERN)
    ) u_usb_det (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .link_clk_i(usb_clk_i),
        .link_dio_i(usb_dio_i),
        .enable_i(det_en),
        .match_o(usb_match)
    );

    always_comb begin
        next_win_cnt = win_cnt;
        next_lock_active = lock_active;
        next_swd_pair = swd_pair;
        next_jtag_en = jtag_en;
        if (!init_done) begin
            // latch output caught once, after reset release
            next_lock_active = vote_now;
            next_jtag_en = !vote_now && cfg_dbg_sel_i == dbg_acq_pkg::CFG_JTAG;
            if (!vote_now && cfg_dbg_sel_i == dbg_acq_pkg::CFG_SWD) begin
                next_swd_pair = dbg_acq_pkg::PAIR_BS;
            end
        end else if (!lock_active) begin
            if (win_cnt < WIN_END) begin
                next_win_cnt = win_cnt + 1'b1;
            end
            // acquisition inside window, one pair only
            if (win_open && swd_pair == dbg_acq_pkg::PAIR_NONE) begin
                if (bs_match) begin
                    next_swd_pair = dbg_acq_pkg::PAIR_BS;
                    next_jtag_en = 1'b0;
                end else if (usb_match) begin
                    next_swd_pair = dbg_acq_pkg::PAIR_USB;
                end
            end
            if (jtag_en && jtag_swd_enable_i) begin
                next_swd_pair = dbg_acq_pkg::PAIR_BS;
                next_jtag_en = 1'b0;
            end else if (swd_pair != dbg_acq_pkg::PAIR_NONE) begin
                if (swd_jtag_enable_i) begin
                    next_jtag_en = 1'b1;
                    if (swd_pair == dbg_acq_pkg::PAIR_BS) begin
                        next_swd_pair = dbg_acq_pkg::PAIR_NONE;
                    end
                end else if (swd_disable_i) begin
                    next_swd_pair = dbg_acq_pkg::PAIR_NONE;
                end
            end
        end
    end

    always_comb begin
        next_vol_key = vol_key;
        next_nv_cells = nv_cells;
        next_refused = 1'b0;
        if (nv_restore_i) begin
            next_nv_cells = nv_image_i;
        end
        // load volatile copy, then commit to cells
        if (lock_key_wr_i) begin
            next_refused = refuse_wr;
            if (!refuse_wr) begin
                next_vol_key = lock_key_i;
            end
        end
        if (lock_commit_i) begin
            next_refused = next_refused || vote_now;
            if (!vote_now && !nv_restore_i) begin
                next_nv_cells = vol_key;
            end
        end
    end

    always_comb begin
        next_grant = 1'b0;
        next_deny = 1'b0;
        next_clear = 1'b0;
        if (flash_req_i) begin
            if (access && op_allowed) begin
                next_grant = 1'b1;
                next_clear = flash_op_i == dbg_acq_pkg::OP_ERASE_ALL;
            end else begin
                next_deny = 1'b1;
            end
        end
        // single pin trace only without scan port
        next_swo_en = !next_lock_active && !next_jtag_en &&
            trace_mode_i == dbg_acq_pkg::TRACE_SINGLE;
        next_par_en = !next_lock_active &&
            trace_mode_i == dbg_acq_pkg::TRACE_PARALLEL;
        next_readback = 32'h0000_0000;
        if (swd_pair != dbg_acq_pkg::PAIR_NONE && !lock_active) begin
            next_readback = nv_cells;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        nv_cells <= next_nv_cells;
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            init_done <= 1'b0;
            win_cnt <= '0;
            lock_active <= 1'b0;
            swd_pair <= dbg_acq_pkg::PAIR_NONE;
            jtag_en <= 1'b0;
            vol_key <= 32'h0000_0000;
            swd_bs_en_o <= 1'b0;
            swd_usb_en_o <= 1'b0;
            jtag_en_o <= 1'b0;
            bs_pins_gpio_o <= 1'b1;
            usb_pins_gpio_o <= 1'b1;
            bs_dio_o <= 1'b0;
            bs_dio_oe_o <= 1'b0;
            usb_dio_o <= 1'b0;
            usb_dio_oe_o <= 1'b0;
            swo_en_o <= 1'b0;
            swo_o <= 1'b0;
            par_trace_en_o <= 1'b0;
            par_trace_o <= 5'h00;
            lock_active_o <= 1'b0;
            lock_vote_o <= 1'b0;
            lock_wr_refused_o <= 1'b0;
            lock_readback_o <= 32'h0000_0000;
            flash_grant_o <= 1'b0;
            flash_deny_o <= 1'b0;
            flash_prot_clear_o <= 1'b0;
        end else begin
            init_done <= 1'b1;
            win_cnt <= next_win_cnt;
            lock_active <= next_lock_active;
            swd_pair <= next_swd_pair;
            jtag_en <= next_jtag_en;
            vol_key <= next_vol_key;
            swd_bs_en_o <= next_swd_pair == dbg_acq_pkg::PAIR_BS;
            swd_usb_en_o <= next_swd_pair == dbg_acq_pkg::PAIR_USB;
            jtag_en_o <= next_jtag_en;
            bs_pins_gpio_o <= !next_jtag_en &&
                next_swd_pair != dbg_acq_pkg::PAIR_BS && !next_swo_en;
            usb_pins_gpio_o <= next_swd_pair != dbg_acq_pkg::PAIR_USB;
            // data pin driven only in the device's turn
            bs_dio_o <= swd_tx_bit_i;
            bs_dio_oe_o <= swd_tx_turn_i &&
                next_swd_pair == dbg_acq_pkg::PAIR_BS;
            usb_dio_o <= swd_tx_bit_i;
            usb_dio_oe_o <= swd_tx_turn_i &&
                next_swd_pair == dbg_acq_pkg::PAIR_USB;
            swo_en_o <= next_swo_en;
            swo_o <= next_swo_en && swo_bit_i;
            par_trace_en_o <= next_par_en;
            par_trace_o <= next_par_en ? trace_word_i : 5'h00;
            lock_active_o <= next_lock_active;
            lock_vote_o <= vote_now;
            lock_wr_refused_o <= next_refused;
            lock_readback_o <= next_readback;
            flash_grant_o <= next_grant;
            flash_deny_o <= next_deny;
            flash_prot_clear_o <= next_clear;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_release_swd;
        !init_done && cfg_dbg_sel_i == dbg_acq_pkg::CFG_SWD && !vote_now;
    endsequence
    sequence s_key_wr_protected;
        lock_key_wr_i && flash_prot_level_i != 2'h0;
    endsequence

    property p_one_pair;
        !(swd_bs_en_o && swd_usb_en_o);
    endproperty
    a_one_pair: assert property (p_one_pair)
        else $error("debug link on both pairs");
    property p_usb_in_window;
        swd_pair == dbg_acq_pkg::PAIR_USB && $past(init_done) &&
            $past(swd_pair) == dbg_acq_pkg::PAIR_NONE
            |-> $past(usb_match) && $past(win_open);
    endproperty
    a_usb_in_window: assert property (p_usb_in_window)
        else $error("usb pair acquired outside window");
    property p_lock_blocks;
        lock_active_o |-> !swd_bs_en_o && !swd_usb_en_o && !jtag_en_o;
    endproperty
    a_lock_blocks: assert property (p_lock_blocks)
        else $error("debug port open under lockout");
    property p_lock_stable;
        init_done && $past(init_done) |-> $stable(lock_active);
    endproperty
    a_lock_stable: assert property (p_lock_stable)
        else $error("lock changed without reset");
    property p_key_refused;
        s_key_wr_protected |=> lock_wr_refused_o ##1 !lock_wr_refused_o
            || $past(lock_key_wr_i);
    endproperty
    a_key_refused: assert property (p_key_refused)
        else $error("key write not refused");
    property p_cfg_swd;
        s_release_swd |=> swd_bs_en_o && !jtag_en_o;
    endproperty
    a_cfg_swd: assert property (p_cfg_swd)
        else $error("latch config did not open scan pair");
    property p_prot_clear;
        flash_prot_clear_o |-> flash_grant_o &&
            $past(flash_op_i) == dbg_acq_pkg::OP_ERASE_ALL;
    endproperty
    a_prot_clear: assert property (p_prot_clear)
        else $error("protection cleared without full erase");
    property p_blk_sec;
        flash_grant_o |-> $past(op_allowed) && $past(access);
    endproperty
    a_blk_sec: assert property (p_blk_sec)
        else $error("block operation not permitted");
    property p_dio_turn;
        bs_dio_oe_o || usb_dio_oe_o |-> $past(swd_tx_turn_i);
    endproperty
    a_dio_turn: assert property (p_dio_turn)
        else $error("data pin driven out of turn");
    property p_swo_excl;
        swo_en_o |-> !jtag_en_o && !bs_pins_gpio_o;
    endproperty
    a_swo_excl: assert property (p_swo_excl)
        else $error("single pin trace with scan port");
    property p_readback;
        lock_readback_o != 32'h0000_0000 |-> $past(swd_pair) !=
            dbg_acq_pkg::PAIR_NONE;
    endproperty
    a_readback: assert property (p_readback)
        else $error("latch read without debug link");
    property p_latch_frozen;
        vote_now && !nv_restore_i |=> $stable(nv_cells);
    endproperty
    a_latch_frozen: assert property (p_latch_frozen)
        else $error("locked latch altered");
endmodule
`default_nettype wire

/* File: dv/debug_host_model.sv */
// host side model that sends the acquire pattern on one pin pair
`timescale 1ns/1ps
`default_nettype none
module debug_host_model (
    input wire logic go_i,
    input wire logic to_usb_i,
    output logic bs_clk_o,
    output logic bs_dio_o,
    output logic usb_clk_o,
    output logic usb_dio_o,
    output logic busy_o
);
    logic clk_v;
    logic dio_v;
    // link clock idles low outside frames, only on the chosen pair
    assign bs_clk_o = to_usb_i ? 1'b0 : clk_v;
    assign usb_clk_o = to_usb_i ? clk_v : 1'b0;
    assign bs_dio_o = dio_v;
    assign usb_dio_o = dio_v;
    initial begin
        clk_v = 1'b0;
        dio_v = 1'b1;
        busy_o = 1'b0;
        forever begin
            @(posedge go_i);
            busy_o = 1'b1;
            // msb first, 125 ns link clock, well under a third
            for (int i = dbg_acq_pkg::ACQ_LEN - 1; i >= 0; i--) begin
                dio_v = dbg_acq_pkg::ACQ_PATTERN[i];
                #62.5 clk_v = 1'b1;
                #62.5 clk_v = 1'b0;
            end
            // released line shows the inverse of the last bit
            dio_v = ~dio_v;
            busy_o = 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: dv/debug_port_acquire_and_lock_bench.sv */
// self-checking bench for debug port acquisition and lockout
`timescale 1ns/1ps
`default_nettype none
module debug_port_acquire_and_lock_bench;
    localparam int WIN = 1000;
    typedef struct packed {
        logic [1:0] op;
        logic [2:0] allow;
        logic [1:0] tm;
        logic [4:0] exp;
    } row_t;
    logic ref_clk, sys_rst, go, to_usb, busy, hb_clk, hb_dio, hu_clk, hu_dio;
    logic bs_pin, usb_pin, bs_do, bs_oe, usb_do, usb_oe, tx_turn, tx_bit;
    logic swd_dis, js_en, sj_en, swo_bit, key_wr, commit, nv_rest, freq;
    logic swd_bs_en, swd_usb_en, jtag_en, bs_gpio, usb_gpio, swo_en, swo;
    logic par_en, lock_active, lock_vote, refused, grant, deny, prot_clr;
    logic [1:0] cfg_sel, trace_mode, prot, fop;
    logic [2:0] fallow;
    logic [4:0] trace_word, par;
    logic [31:0] key, nv_img, readback;
    int miscompares = 0;
    int n_checks = 0;
    row_t rows [7] = '{
        '{dbg_acq_pkg::OP_ERASE_ALL, 3'h0, dbg_acq_pkg::TRACE_OFF, 5'h14},
        '{dbg_acq_pkg::OP_ERASE_BLK, 3'h1, dbg_acq_pkg::TRACE_SINGLE, 5'h12},
        '{dbg_acq_pkg::OP_ERASE_BLK, 3'h6, dbg_acq_pkg::TRACE_PARALLEL, 5'h09},
        '{dbg_acq_pkg::OP_PROGRAM, 3'h2, dbg_acq_pkg::TRACE_OFF, 5'h10},
        '{dbg_acq_pkg::OP_PROGRAM, 3'h5, dbg_acq_pkg::TRACE_SINGLE, 5'h0A},
        '{dbg_acq_pkg::OP_VERIFY, 3'h4, dbg_acq_pkg::TRACE_PARALLEL, 5'h11},
        '{dbg_acq_pkg::OP_VERIFY, 3'h3, dbg_acq_pkg::TRACE_OFF, 5'h08}
    };
    // wire level from both drivers of each data pin
    assign bs_pin = bs_oe ? bs_do : hb_dio;
    assign usb_pin = usb_oe ? usb_do : hu_dio;
    debug_host_model debug_host_model_i (.go_i(go), .to_usb_i(to_usb),
        .bs_clk_o(hb_clk), .bs_dio_o(hb_dio), .usb_clk_o(hu_clk),
        .usb_dio_o(hu_dio), .busy_o(busy));
    debug_port_acquire_and_lock #(.KEY_WIN_CYC(WIN))
        debug_port_acquire_and_lock_i (.ref_clk_i(ref_clk),
        .sys_rst_i(sys_rst), .bs_clk_i(hb_clk), .bs_dio_i(bs_pin),
        .bs_dio_o(bs_do), .bs_dio_oe_o(bs_oe), .usb_clk_i(hu_clk),
        .usb_dio_i(usb_pin), .usb_dio_o(usb_do), .usb_dio_oe_o(usb_oe),
        .cfg_dbg_sel_i(cfg_sel), .swd_tx_turn_i(tx_turn),
        .swd_tx_bit_i(tx_bit), .swd_disable_i(swd_dis),
        .jtag_swd_enable_i(js_en), .swd_jtag_enable_i(sj_en),
        .trace_mode_i(trace_mode), .swo_bit_i(swo_bit),
        .trace_word_i(trace_word), .lock_key_i(key), .lock_key_wr_i(key_wr),
        .lock_commit_i(commit), .nv_restore_i(nv_rest), .nv_image_i(nv_img),
        .flash_prot_level_i(prot), .flash_req_i(freq), .flash_op_i(fop),
        .blk_sec_allow_i(fallow), .swd_bs_en_o(swd_bs_en),
        .swd_usb_en_o(swd_usb_en), .jtag_en_o(jtag_en),
        .bs_pins_gpio_o(bs_gpio), .usb_pins_gpio_o(usb_gpio),
        .swo_en_o(swo_en), .swo_o(swo), .par_trace_en_o(par_en),
        .par_trace_o(par), .lock_active_o(lock_active),
        .lock_vote_o(lock_vote), .lock_wr_refused_o(refused),
        .lock_readback_o(readback), .flash_grant_o(grant),
        .flash_deny_o(deny), .flash_prot_clear_o(prot_clr));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    task automatic do_reset(input logic [1:0] sel);
        sys_rst = 1'b1;
        cfg_sel = sel;
        tick(3);
        nv_rest = 1'b0;
        sys_rst = 1'b0;
        tick(2);
    endtask
    task automatic send(input logic usb);
        to_usb = usb;
        go = 1'b1;
        tick(1);
        go = 1'b0;
        for (int k = 0; k < 1000 && busy; k++)
            tick(1);
        chk("host idle", busy, 1'b0);
        tick(10);
    endtask
    task automatic flash(input logic [1:0] op, input logic [2:0] al);
        fop = op;
        fallow = al;
        pulse(freq);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        close_out;
    end
    initial begin
        {sys_rst, nv_rest} = 2'h3;
        {go, to_usb, tx_turn, tx_bit, swd_dis, js_en, sj_en} = 7'h00;
        {swo_bit, key_wr, commit, freq, prot, fop, fallow} = 11'h000;
        {trace_mode, trace_word, cfg_sel} = 9'h000;
        key = 32'h0000_0000;
        nv_img = 32'h0000_0000;
        do_reset(dbg_acq_pkg::CFG_SWD);
        chk("cfg link", {swd_bs_en, jtag_en, bs_gpio}, 3'h4);
        swo_bit = 1'b1;
        trace_word = 5'h15;
        foreach (rows[i]) begin
            trace_mode = rows[i].tm;
            flash(rows[i].op, rows[i].allow);
            chk("flash", {grant, deny, prot_clr},
                rows[i].exp[4:2]);
            tick(1);
            chk("trace", {swo_en, swo, par_en},
                {rows[i].exp[1], rows[i].exp[1:0]});
            chk("par", par, rows[i].exp[0] ? 5'h15 : 5'h00);
        end
        trace_mode = dbg_acq_pkg::TRACE_OFF;
        tx_bit = 1'b1;
        tx_turn = 1'b1;
        tick(2);
        chk("drive", {bs_oe, bs_pin, usb_oe}, 3'h6);
        tx_turn = 1'b0;
        tick(2);
        chk("release", bs_oe, 1'b0);
        do_reset(dbg_acq_pkg::CFG_NONE);
        send(1'b1);
        chk("usb acq", {swd_usb_en, swd_bs_en, usb_gpio}, 3'h4);
        tx_turn = 1'b1;
        tick(2);
        chk("usb drive", {usb_oe, usb_pin, bs_oe}, 3'h6);
        tx_turn = 1'b0;
        tick(2);
        send(1'b0);
        chk("one pair", swd_bs_en, 1'b0);
        do_reset(dbg_acq_pkg::CFG_NONE);
        tick(WIN + 100);
        send(1'b0);
        chk("late", swd_bs_en, 1'b0);
        do_reset(dbg_acq_pkg::CFG_JTAG);
        chk("cfg scan", {jtag_en, swd_bs_en, bs_gpio}, 3'h4);
        send(1'b0);
        chk("bs acq", {swd_bs_en, jtag_en, bs_gpio}, 3'h4);
        pulse(sj_en);
        chk("scan on", {swd_bs_en, jtag_en}, 2'h1);
        trace_mode = dbg_acq_pkg::TRACE_SINGLE;
        tick(2);
        chk("swo vs scan", swo_en, 1'b0);
        trace_mode = dbg_acq_pkg::TRACE_OFF;
        pulse(js_en);
        chk("link back", {swd_bs_en, jtag_en}, 2'h2);
        pulse(swd_dis);
        chk("gpio", {swd_bs_en, bs_gpio}, 2'h1);
        do_reset(dbg_acq_pkg::CFG_SWD);
        nv_img = dbg_acq_pkg::LOCK_KEY ^ 32'h0000_000F;
        pulse(nv_rest);
        tick(2);
        chk("vote 28", lock_vote, 1'b1);
        nv_img = dbg_acq_pkg::LOCK_KEY ^ 32'h0000_001F;
        pulse(nv_rest);
        tick(2);
        chk("vote 27", lock_vote, 1'b0);
        key = dbg_acq_pkg::LOCK_KEY;
        prot = 2'h1;
        pulse(key_wr);
        chk("key prot", refused, 1'b1);
        prot = 2'h0;
        tick(1);
        pulse(key_wr);
        chk("key ok", refused, 1'b0);
        pulse(commit);
        tick(2);
        chk("armed", {lock_vote, lock_active, swd_bs_en},
            3'h5);
        chk("readback", readback, dbg_acq_pkg::LOCK_KEY);
        pulse(key_wr);
        chk("key again", refused, 1'b1);
        do_reset(dbg_acq_pkg::CFG_SWD);
        chk("locked", {lock_active, swd_bs_en, jtag_en}, 3'h4);
        flash(dbg_acq_pkg::OP_ERASE_ALL, 3'h0);
        chk("locked erase", {grant, deny}, 2'h1);
        send(1'b1);
        chk("locked acq", swd_usb_en, 1'b0);
        close_out;
    end
endmodule
`default_nettype wire
